// ---- eeprom_array.sv ----
// Storage array and identification page with a registered read port.
// Assumes the engine holds the read address steady while it needs data.
`timescale 1ns/10ps
`include "eeprom_consts.svh"
module eeprom_array (
  // Array access
  mem_if.array m
);
  logic [7:0] arr_mem [`ARRAY_WORDS];
  logic [7:0] id_mem  [`ID_WORDS];
  logic [7:0] rdata_reg;

  // Cells are non-volatile, so reset leaves them alone.
  always_ff @(posedge m.clk) begin
    if (m.we && m.wid) begin
      id_mem[m.waddr[`ID_AW-1:0]] <= m.wdata;
    end else if (m.we) begin
      arr_mem[m.waddr] <= m.wdata;
    end
  end

  always_ff @(posedge m.clk) begin
    if (!m.rst_n) begin
      rdata_reg <= `BYTE_ZERO;
    end else if (m.rid) begin
      rdata_reg <= id_mem[m.raddr[`ID_AW-1:0]];
    end else begin
      rdata_reg <= arr_mem[m.raddr];
    end
  end

  assign m.rdata = rdata_reg;
endmodule

// ---- eeprom_consts.svh ----
// Named constants for the serial EEPROM bus front end.
// Assumes inclusion by bare name from every file that needs them.
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define ADDR_W      14
`define ID_AW       6
`define ARRAY_WORDS 16384
`define ID_WORDS    64
`define BIT_LAST    4'h7
`define BIT_ACK     4'h8
`define BIT_ZERO    4'h0
`define BIT_ONE     4'h1
`define SEL_RW      0
`define SEL_CS_HI   3
`define SEL_CS_LO   1
`define SEL_TY_HI   7
`define SEL_TY_LO   4
`define AHI_LOCK    2
`define LOCK_DBIT   1
`define ADDR_ONE    14'h0001
`define ADDR_ZERO   14'h0000
`define BYTE_ZERO   8'h00
`endif

// ---- eeprom_ifs.sv ----
// Interfaces between the protocol engine, the line front end and the array.
// Assumes one system clock and its synchronous active-low reset.
`timescale 1ns/10ps
interface link_if (input wire logic clk, input wire logic rst_n);
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       bit_val;
  logic       wp;
  logic [2:0] cs;
  modport front  (input clk, input rst_n,
                  output rise, fall, start, stop, bit_val, wp, cs);
  modport engine (input rise, fall, start, stop, bit_val, wp, cs);
endinterface

interface mem_if (input wire logic clk, input wire logic rst_n);
  logic        we;
  logic        wid;
  logic        rid;
  logic [13:0] waddr;
  logic [13:0] raddr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport ctrl  (output we, wid, rid, waddr, raddr, wdata, input rdata);
  modport array (input clk, rst_n, we, wid, rid, waddr, raddr, wdata,
                 output rdata);
endinterface

// ---- eeprom_pkg.sv ----
// Types shared by the serial EEPROM bus front end.
// Assumes nothing of its surroundings.
package eeprom_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SEL   = 7'h02,
    ST_AHI   = 7'h04,
    ST_ALO   = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_BUSY  = 7'h40
  } state_t;
endpackage

// ---- eeprom_slave.sv ----
// Slave-side two-wire bus front end of a byte-addressed serial EEPROM.
// Assumes a master that supplies the serial clock and pull-ups on the line.
// Operation
// [R1] Byte-addressed array of sixteen thousand eight-bit cells reachable over the bus.
// [R2] Separate sixty-four byte identification page, read-only once locked; the lock here is cleared by reset.
// [R3] Serial clock captures incoming bits and paces outgoing bits.
// [R4] Data line is driven only low or released, open drain.
// [R5] Chip-select pins compare against select code bits 3, 2 and 1.
// [R6] Unconnected chip-select pins count as zero; here board pull-downs must supply the zero.
// [R7] Write protect high blocks every array write; low permits.
// [R8] Under write protect, select and address bytes acked, data bytes not.
// [R9] Ignore bus until power-on reset releases, then reset and stand by.
// [R10] Power-on reset asserted again stops all responses.
// [R11] Stop enters standby unless an internal write cycle runs.
// [R12] Start is data falling while clock high; master precedes every transfer.
// [R13] Watch for start at all times except during the write cycle.
// [R14] Stop is data rising while clock high; it ends the transaction.
// [R15] Read byte refused by master then stop returns to standby.
// [R16] Stop completing a write instruction starts the internal write cycle.
// [R17] Capture data level on each rising serial clock edge.
// [R18] Master keeps data steady over rising clock, changes it while low.
// [R19] Transmitter releases after eight bits; receiver pulls low on ninth.
// [R20] Device is slave only: never starts transfers nor drives clock.
// [R21] Select byte arrives MSB first: type, chip selects, direction bit.
// [R22] Select match acks on ninth bit; mismatch releases, waits for start.
// [R23] Clock and data inputs are synchronised before edge detection.
// [R24] Start in mid-transfer abandons it and restarts select reception.
`timescale 1ns/10ps
`include "eeprom_consts.svh"
module eeprom_slave #(
  // Arbitrary type codes for the array and the identification page.
  parameter logic [3:0] ARRAY_TYPE   = 4'h5,
  parameter logic [3:0] IDPAGE_TYPE  = 4'h6,
  // Length of the internal write cycle in system clocks.
  parameter int         WRITE_CYCLES = 1000
) (
  // System
  input wire logic       clk,
  input wire logic       rst_n,
  // Serial bus
  input wire logic       scl,
  input wire logic       sda_in,
  output logic           sda_out,
  output logic           sda_oe,
  // Straps and protection
  input wire logic [2:0] chip_select_pins,
  input wire logic       write_protect_in,
  // Status
  output logic           standby,
  output logic           write_busy
);
  eeprom_pkg::state_t state_reg;
  logic [3:0]         cnt_reg;
  logic [7:0]         shift_reg;
  logic [7:0]         tx_reg;
  logic [7:0]         wdata_reg;
  logic [13:0]        addr_reg;
  logic               ack_reg;
  logic               idsel_reg;
  logic               lockcmd_reg;
  logic               locked_reg;
  logic               pend_reg;
  logic               we_reg;
  logic [31:0]        wcnt_reg;
  logic               sda_oe_reg;
  logic               sda_out_reg;
  logic               standby_reg;
  logic               busy_reg;
  logic [7:0]         byte_in;
  logic               sel_match;
  logic               wdone;
  logic               commit;
  logic               tx_bit;
  logic               rx_state;

  link_if lk (.clk(clk), .rst_n(rst_n));
  mem_if  m  (.clk(clk), .rst_n(rst_n));

  // Chip-select pins need board pull-downs so a floating pin reads as zero.
  line_front u_front (
    .scl     (scl),
    .sda_in  (sda_in),
    .cs_pins (chip_select_pins),
    .wp_pin  (write_protect_in),
    .lk      (lk)
  );

  eeprom_array u_array (
    .m (m)
  );

  assign byte_in   = {shift_reg[6:0], lk.bit_val};
  assign sel_match = (byte_in[`SEL_TY_HI:`SEL_TY_LO] == ARRAY_TYPE
                      || byte_in[`SEL_TY_HI:`SEL_TY_LO] == IDPAGE_TYPE)
                     && byte_in[`SEL_CS_HI:`SEL_CS_LO] == lk.cs; // R5 R6 R21
  assign wdone     = wcnt_reg == 32'(WRITE_CYCLES - 1);
  // The clock rise that carries a stop is counted as the first bit of a
  // next byte, so a stop in the slot after a data ack sees one bit.
  assign commit    = state_reg == eeprom_pkg::ST_WDATA
                     && cnt_reg == `BIT_ONE && pend_reg;
  assign tx_bit    = tx_reg[3'(`BIT_LAST - cnt_reg)];
  assign rx_state  = state_reg == eeprom_pkg::ST_SEL
                     || state_reg == eeprom_pkg::ST_AHI
                     || state_reg == eeprom_pkg::ST_ALO
                     || state_reg == eeprom_pkg::ST_WDATA;

  assign m.we    = we_reg;
  assign m.wid   = idsel_reg;
  assign m.rid   = idsel_reg;
  assign m.waddr = addr_reg;
  assign m.raddr = addr_reg;
  assign m.wdata = wdata_reg;

  // Protocol engine. Reset is the power-on reset: while it is held the
  // engine sits idle and the line stays released.
  always_ff @(posedge clk) begin
    if (!rst_n) begin // R9 R10
      state_reg   <= eeprom_pkg::ST_IDLE;
      cnt_reg     <= `BIT_ZERO;
      shift_reg   <= `BYTE_ZERO;
      tx_reg      <= `BYTE_ZERO;
      wdata_reg   <= `BYTE_ZERO;
      addr_reg    <= `ADDR_ZERO;
      ack_reg     <= 1'b0;
      idsel_reg   <= 1'b0;
      lockcmd_reg <= 1'b0;
      locked_reg  <= 1'b0;
      pend_reg    <= 1'b0;
      we_reg      <= 1'b0;
    end else begin
      we_reg <= 1'b0;
      if (state_reg == eeprom_pkg::ST_BUSY) begin // R13
        if (wdone) begin
          state_reg <= eeprom_pkg::ST_IDLE;
          pend_reg  <= 1'b0;
          if (!(idsel_reg && lockcmd_reg)) begin
            addr_reg <= addr_reg + `ADDR_ONE;
          end
        end
      end else if (lk.start) begin // R12 R24
        state_reg <= eeprom_pkg::ST_SEL;
        cnt_reg   <= `BIT_ZERO;
        ack_reg   <= 1'b0;
        pend_reg  <= 1'b0;
      end else if (lk.stop) begin // R14
        ack_reg <= 1'b0;
        if (commit) begin // R16
          state_reg <= eeprom_pkg::ST_BUSY;
          if (idsel_reg && lockcmd_reg) begin // R2
            locked_reg <= locked_reg || wdata_reg[`LOCK_DBIT];
          end else begin
            we_reg <= 1'b1; // R1
          end
        end else begin
          state_reg <= eeprom_pkg::ST_IDLE; // R11 R15
          pend_reg  <= 1'b0;
        end
      end else if (lk.rise && state_reg != eeprom_pkg::ST_IDLE) begin // R17
        if (cnt_reg != `BIT_ACK) begin
          shift_reg <= byte_in; // R3
          cnt_reg   <= cnt_reg + `BIT_ONE;
          if (cnt_reg == `BIT_LAST) begin
            case (state_reg)
              eeprom_pkg::ST_SEL: begin
                ack_reg <= sel_match; // R22
              end
              eeprom_pkg::ST_AHI, eeprom_pkg::ST_ALO: begin
                ack_reg <= 1'b1; // R8
              end
              eeprom_pkg::ST_WDATA: begin
                ack_reg <= !lk.wp && !(idsel_reg && locked_reg); // R7 R8 R2
              end
              default: begin
                ack_reg <= 1'b0;
              end
            endcase
          end
        end else begin
          cnt_reg <= `BIT_ZERO;
          ack_reg <= 1'b0;
          case (state_reg)
            eeprom_pkg::ST_SEL: begin
              if (!ack_reg) begin
                state_reg <= eeprom_pkg::ST_IDLE; // R22
              end else begin
                idsel_reg <= shift_reg[`SEL_TY_HI:`SEL_TY_LO] == IDPAGE_TYPE;
                if (shift_reg[`SEL_RW]) begin // R21
                  state_reg <= eeprom_pkg::ST_RDATA;
                  tx_reg    <= m.rdata;
                  addr_reg  <= addr_reg + `ADDR_ONE;
                end else begin
                  state_reg <= eeprom_pkg::ST_AHI;
                end
              end
            end
            eeprom_pkg::ST_AHI: begin
              addr_reg[13:8] <= shift_reg[5:0];
              lockcmd_reg    <= shift_reg[`AHI_LOCK];
              state_reg      <= eeprom_pkg::ST_ALO;
            end
            eeprom_pkg::ST_ALO: begin
              addr_reg[7:0] <= shift_reg;
              state_reg     <= eeprom_pkg::ST_WDATA;
            end
            eeprom_pkg::ST_WDATA: begin
              // Only the last accepted byte is kept; page buffering is
              // left to a wider array port.
              pend_reg <= ack_reg;
              if (ack_reg) begin
                wdata_reg <= shift_reg;
              end
            end
            eeprom_pkg::ST_RDATA: begin
              if (lk.bit_val) begin
                state_reg <= eeprom_pkg::ST_IDLE; // R15
              end else begin
                tx_reg   <= m.rdata;
                addr_reg <= addr_reg + `ADDR_ONE;
              end
            end
            default: begin
              state_reg <= eeprom_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Internal write cycle timer.
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != eeprom_pkg::ST_BUSY) begin
      wcnt_reg <= 32'h00000000;
    end else begin
      wcnt_reg <= wcnt_reg + 32'h00000001;
    end
  end

  // Line driver. The line is pulled low only on the falling serial clock, so the master never sees it
  // fall while the clock is high; idle, the write cycle, start and stop release it at once.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0; // R4
      if (state_reg == eeprom_pkg::ST_IDLE || state_reg == eeprom_pkg::ST_BUSY
          || lk.start || lk.stop) begin
        sda_oe_reg <= 1'b0; // R20
      end else if (lk.fall) begin // R3 R19
        sda_oe_reg <= (cnt_reg == `BIT_ACK && ack_reg)
                      || (state_reg == eeprom_pkg::ST_RDATA
                          && cnt_reg != `BIT_ACK && !tx_bit);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_reg <= 1'b0;
      busy_reg    <= 1'b0;
    end else begin
      standby_reg <= state_reg == eeprom_pkg::ST_IDLE; // R11
      busy_reg    <= state_reg == eeprom_pkg::ST_BUSY;
    end
  end

  assign sda_out    = sda_out_reg;
  assign sda_oe     = sda_oe_reg;
  assign standby    = standby_reg;
  assign write_busy = busy_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  reset_idle_a: assert property ( // R9
    disable iff (1'b0) !rst_n |=> state_reg == eeprom_pkg::ST_IDLE && !sda_oe_reg)
    else $error("Engine not idle after reset.");

  busy_quiet_a: assert property ( // R13
    state_reg == eeprom_pkg::ST_BUSY && lk.start |=> state_reg != eeprom_pkg::ST_SEL
      && !sda_oe_reg)
    else $error("Start taken during write cycle.");

  start_restart_a: assert property ( // R24
    lk.start && state_reg != eeprom_pkg::ST_BUSY
      |=> state_reg == eeprom_pkg::ST_SEL && cnt_reg == `BIT_ZERO)
    else $error("Start did not restart select reception.");

  stop_commit_a: assert property ( // R16
    lk.stop && commit && state_reg != eeprom_pkg::ST_BUSY
      |=> state_reg == eeprom_pkg::ST_BUSY ##1 busy_reg)
    else $error("Stop after data did not start write cycle.");

  stop_idle_a: assert property ( // R11
    lk.stop && !commit && state_reg != eeprom_pkg::ST_BUSY
      |=> state_reg == eeprom_pkg::ST_IDLE ##1 standby_reg)
    else $error("Stop did not return to standby.");

  wp_nack_a: assert property ( // R8
    state_reg == eeprom_pkg::ST_WDATA && lk.rise && cnt_reg == `BIT_LAST
      && lk.wp && !lk.start && !lk.stop |=> !ack_reg)
    else $error("Data byte acked under write protect.");

  addr_ack_a: assert property ( // R8
    (state_reg == eeprom_pkg::ST_AHI || state_reg == eeprom_pkg::ST_ALO)
      && lk.rise && cnt_reg == `BIT_LAST && !lk.start && !lk.stop |=> ack_reg)
    else $error("Address byte not acked.");

  sel_miss_a: assert property ( // R22
    state_reg == eeprom_pkg::ST_SEL && lk.rise && cnt_reg == `BIT_ACK && !ack_reg
      && !lk.start && !lk.stop |=> state_reg == eeprom_pkg::ST_IDLE ##1 !sda_oe_reg)
    else $error("Mismatched select did not release the bus.");

  ack_drive_a: assert property ( // R19
    lk.fall && rx_state && cnt_reg == `BIT_ACK && ack_reg && !lk.start && !lk.stop
      |=> sda_oe_reg)
    else $error("Acknowledge not driven in ninth slot.");

  tx_bit_a: assert property ( // R3
    lk.fall && state_reg == eeprom_pkg::ST_RDATA && cnt_reg != `BIT_ACK
      && !lk.start && !lk.stop |=> sda_oe_reg == !$past(tx_bit))
    else $error("Read bit driven wrongly.");

  write_len_a: assert property ( // R16
    $rose(busy_reg) |-> busy_reg [*8])
    else $error("Write cycle ended too early.");

  lock_nack_a: assert property ( // R2
    state_reg == eeprom_pkg::ST_WDATA && lk.rise && cnt_reg == `BIT_LAST && idsel_reg
      && locked_reg && !lk.start && !lk.stop |=> !ack_reg)
    else $error("Data byte acked on locked page.");

  busy_hold_a: assert property ( // R13
    state_reg == eeprom_pkg::ST_BUSY && !wdone |=> state_reg == eeprom_pkg::ST_BUSY)
    else $error("Write cycle left before its end.");

  read_turn_a: assert property ( // R21
    state_reg == eeprom_pkg::ST_SEL && lk.rise && cnt_reg == `BIT_ACK && ack_reg
      && shift_reg[`SEL_RW] && !lk.start && !lk.stop |=> state_reg == eeprom_pkg::ST_RDATA)
    else $error("Read select did not turn the bus.");

  read_nack_a: assert property ( // R15
    state_reg == eeprom_pkg::ST_RDATA && lk.rise && cnt_reg == `BIT_ACK && lk.bit_val
      && !lk.start && !lk.stop |=> state_reg == eeprom_pkg::ST_IDLE)
    else $error("Refused read byte did not end the read.");

  rx_release_a: assert property ( // R19
    lk.fall && rx_state && cnt_reg != `BIT_ACK && !lk.start && !lk.stop |=> !sda_oe_reg)
    else $error("Data line held outside the acknowledge slot.");
endmodule

// ---- i2c_master_model.sv ----
// Two-wire bus master model that supplies the serial clock and pulls the data line.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/10ps
module i2c_master_model (
  // Bus
  input  wire logic       sda_line,
  output logic            scl = 1'b1,
  output logic            sda_pull = 1'b0,
  // Results towards the scoreboard
  output logic            res_stb = 1'b0,
  output logic            res_kind = 1'b0,
  output logic [7:0]      res_val = 8'h00
);
  localparam int QTR = 40;

  // The clock stands high between frames and only toggles inside a task.
  task automatic start_cond();
    sda_pull = 1'b0;
    // A fixed skew keeps the serial edges off the system clock edges.
    while (($time % 10) != 3) #1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic clock_bit(input logic b, output logic seen);
    while (($time % 10) != 3) #1;
    sda_pull = ~b;
    #QTR scl = 1'b1;
    #QTR seen = sda_line;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic post(input logic k, input logic [7:0] v);
    res_kind = k;
    res_val = v;
    #1 res_stb = 1'b1;
    #1 res_stb = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(v[i], s);
    clock_bit(1'b1, s);
    post(1'b0, {7'h00, s});
  endtask

  task automatic recv_byte(input logic nack);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, v[i]);
    clock_bit(nack, s);
    post(1'b1, v);
  endtask

  task automatic stop_cond();
    while (($time % 10) != 3) #1;
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #(2 * QTR);
  endtask
endmodule

// ---- line_front.sv ----
// Line front end: captures data on the serial clock and finds bus events.
// Assumes the serial clock high time spans at least four system clocks.
`timescale 1ns/10ps
module line_front (
  // Bus pins
  input wire logic scl,
  input wire logic sda_in,
  input wire logic [2:0] cs_pins,
  input wire logic wp_pin,
  // Events towards the engine
  link_if.front    lk
);
  logic       cap_reg;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [2:0] cs_s1;
  logic [2:0] cs_s2;
  logic       wp_s1;
  logic       wp_s2;

  // The bit is held from this edge to the next, so the engine may read it
  // once the synchronised clock shows the rise.
  always_ff @(posedge scl) begin
    cap_reg <= sda_in;
  end

  always_ff @(posedge lk.clk) begin
    if (!lk.rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      cs_s1 <= 3'h0;
      cs_s2 <= 3'h0;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], scl}; // R23
      sda_s <= {sda_s[1:0], sda_in};
      cs_s1 <= cs_pins;
      cs_s2 <= cs_s1;
      wp_s1 <= wp_pin;
      wp_s2 <= wp_s1;
    end
  end

  assign lk.rise    = scl_s[1] && !scl_s[2];
  assign lk.fall    = !scl_s[1] && scl_s[2];
  assign lk.start   = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  assign lk.stop    = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
  assign lk.bit_val = cap_reg;
  assign lk.cs      = cs_s2;
  assign lk.wp      = wp_s2;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the serial EEPROM bus front end.
// Assumes the master model on the far side and a pull-up on the data line.
`timescale 1ns/10ps
module tb_top;
  localparam logic [3:0] ARR_T = 4'h5;
  localparam logic [3:0] ID_T  = 4'h6;
  logic       clk = 1'b0;
  logic       rst_n;
  logic [2:0] cs_pins;
  logic       wp;
  logic       scl;
  logic       mst_pull;
  logic       res_stb;
  logic       res_kind;
  logic [7:0] res_val;
  logic       sda_out;
  logic       sda_oe;
  logic       standby;
  logic       write_busy;
  wire        sda_line = ~(sda_oe | mst_pull);
  logic [8:0] expq[$];
  int         mismatches = 0;
  int         checks_done = 0;

  always #5 clk = ~clk;

  eeprom_slave #(.ARRAY_TYPE(ARR_T), .IDPAGE_TYPE(ID_T), .WRITE_CYCLES(400)) eeprom_slave_i (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_pins(cs_pins), .write_protect_in(wp),
    .standby(standby), .write_busy(write_busy));

  i2c_master_model i2c_master_model_i (
    .sda_line(sda_line), .scl(scl), .sda_pull(mst_pull),
    .res_stb(res_stb), .res_kind(res_kind), .res_val(res_val));

  task automatic summarize();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic compare_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic compare_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // The watcher takes the oldest note whenever the master reports a result.
  always @(posedge res_stb) begin
    logic [8:0] e;
    if (expq.size() == 0) begin
      compare_bit("unnoted result", 1'b0, 1'b1);
    end else begin
      e = expq.pop_front();
      compare_bit("result kind", e[8], res_kind);
      if (e[8]) compare_byte("read byte", e[7:0], res_val);
      else compare_bit("ack level", e[0], res_val[0]);
    end
  end

  always @(posedge clk) begin
    if (rst_n && sda_oe === 1'b1) compare_bit("sda_out", 1'b0, sda_out);
  end

  task automatic wr(input logic [7:0] b, input logic ack);
    expq.push_back({1'b0, 7'h00, ~ack});
    i2c_master_model_i.send_byte(b);
  endtask

  task automatic write_one(input logic [3:0] t, input logic [7:0] hi, lo, d, input logic dack);
    i2c_master_model_i.start_cond();
    wr({t, cs_pins, 1'b0}, 1'b1);
    wr(hi, 1'b1);
    wr(lo, 1'b1);
    wr(d, dack);
    i2c_master_model_i.stop_cond();
  endtask

  task automatic read_one(input logic [3:0] t, input logic [7:0] hi, lo, d);
    i2c_master_model_i.start_cond();
    wr({t, cs_pins, 1'b0}, 1'b1);
    wr(hi, 1'b1);
    wr(lo, 1'b1);
    i2c_master_model_i.start_cond();
    wr({t, cs_pins, 1'b1}, 1'b1);
    expq.push_back({1'b1, d});
    i2c_master_model_i.recv_byte(1'b1);
    i2c_master_model_i.stop_cond();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (standby !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    compare_bit("standby", 1'b1, standby);
    if (standby !== 1'b1) summarize();
  endtask

  initial begin
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] d;
    int         seed_v;
    seed_v = $urandom(32'h4CDBC258);
    rst_n <= 1'b0;
    wp <= 1'b0;
    cs_pins <= 3'($urandom_range(7, 0));
    repeat (4) @(posedge clk);
    #1 compare_bit("standby in reset", 1'b0, standby);
    compare_bit("oe in reset", 1'b0, sda_oe);
    @(posedge clk) rst_n <= 1'b1;
    wait_idle();
    for (int k = 0; k < 2; k++) begin
      hi = 8'($urandom) & 8'h3B;
      lo = 8'($urandom);
      d = 8'($urandom);
      write_one(k ? ID_T : ARR_T, hi, lo, d, 1'b1);
      #1 compare_bit("busy after stop", 1'b1, write_busy);
      compare_bit("standby in write", 1'b0, standby);
      i2c_master_model_i.start_cond();
      wr({ARR_T, cs_pins, 1'b0}, 1'b0);
      i2c_master_model_i.stop_cond();
      wait_idle();
      read_one(k ? ID_T : ARR_T, hi, lo, d);
      wait_idle();
      @(posedge clk) wp <= 1'b1;
      write_one(k ? ID_T : ARR_T, hi, lo, ~d, 1'b0);
      repeat (5) @(posedge clk);
      #1 compare_bit("busy under protect", 1'b0, write_busy);
      @(posedge clk) wp <= 1'b0;
      read_one(k ? ID_T : ARR_T, hi, lo, d);
      wait_idle();
    end
    write_one(ID_T, 8'h04, 8'h00, 8'h02, 1'b1);
    wait_idle();
    write_one(ID_T, hi, lo, ~d, 1'b0);
    wait_idle();
    read_one(ID_T, hi, lo, d);
    wait_idle();
    for (int b = 0; b < 4; b++) begin
      i2c_master_model_i.start_cond();
      wr(b < 3 ? {ARR_T, cs_pins ^ 3'(1 << b), 1'b0} : {4'h0, cs_pins, 1'b0}, 1'b0);
      wr(8'h00, 1'b0);
      i2c_master_model_i.stop_cond();
    end
    @(posedge clk) cs_pins <= 3'b000;
    i2c_master_model_i.start_cond();
    for (int b = 0; b < 4; b++) i2c_master_model_i.clock_bit(1'b1, d[b]);
    i2c_master_model_i.start_cond();
    wr({ARR_T, 3'b000, 1'b0}, 1'b1);
    i2c_master_model_i.stop_cond();
    i2c_master_model_i.start_cond();
    wr({ARR_T, 3'b000, 1'b0}, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    wr(8'h00, 1'b0);
    #1 compare_bit("standby in reset", 1'b0, standby);
    i2c_master_model_i.stop_cond();
    @(posedge clk) rst_n <= 1'b1;
    wait_idle();
    compare_bit("notes left", 1'b0, expq.size() != 0);
    summarize();
  end
endmodule
